// ==== rtl/csc_config.sv ====
`include "csc_defines.svh"

module csc_config (
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_rst_n,
  input  wire csc_pkg::csc_reg_req_t   i_reg_req,
  input  wire csc_pkg::csc_status_t    i_conv_status,
  output logic [7:0]                   o_reg_rdata,
  output csc_pkg::csc_conv_ctrl_t      o_conv_ctrl,
  output logic                         o_card_deactivate,
  output logic [3:0]                   o_regulator_current_boost
);

  //////////////////////////////////////////////////////////////////////////////
  // read value helpers

  function automatic logic [7:0] conv_read_value(
    input csc_pkg::csc_state_t st,
    input logic                good
  );
    logic [7:0] v;
    v                              = `CSC_CONV_RESET;
    v[`CSC_CONV_POWER_OFF]         = st.power_off;
    v[`CSC_CONV_IRQ_FLAG]          = st.irq_flag;
    v[`CSC_CONV_OUTPUT_GOOD]       = good;
    v[`CSC_CONV_ZERO_BIT]          = 1'b0;
    v[`CSC_CONV_SENS_ADJUST]       = st.sens_adjust;
    v[`CSC_CONV_STEP_DISABLE]      = st.step_disable;
    v[`CSC_CONV_CODE_MSB:`CSC_CONV_CODE_LSB] = st.code;
    return v;
  endfunction : conv_read_value

  function automatic logic [7:0] reg_read_value(
    input csc_pkg::csc_state_t st
  );
    logic [7:0] v;
    v                                        = `CSC_REG_RESET;
    v[`CSC_REG_BOOST_MSB:`CSC_REG_BOOST_LSB] = st.boost;
    v[`CSC_REG_FIXED_MSB:`CSC_REG_FIXED_LSB] = `CSC_REG_FIXED_VALUE;
    return v;
  endfunction : reg_read_value

  //////////////////////////////////////////////////////////////////////////////
  // status synchronisation

  csc_pkg::csc_status_t status_sync;

  csc_sync u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_async   (i_conv_status),
    .o_sync    (status_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register state

  csc_pkg::csc_state_t state_q;
  csc_pkg::csc_state_t state_d;

  logic conv_wr;
  logic conv_rd;
  logic regu_wr;
  logic regu_rd;
  logic card_good_rise;
  logic output_good;

  assign conv_wr = i_reg_req.wr && (i_reg_req.sel == `CSC_IDX_CONVERTER);
  assign conv_rd = i_reg_req.rd && (i_reg_req.sel == `CSC_IDX_CONVERTER);
  assign regu_wr = i_reg_req.wr && (i_reg_req.sel == `CSC_IDX_REGULATOR);
  assign regu_rd = i_reg_req.rd && (i_reg_req.sel == `CSC_IDX_REGULATOR);

  // rising edge of the synchronised card voltage good level
  assign card_good_rise = status_sync.card_good && !state_q.card_good_prev;

  // a stopped converter never reports good output
  assign output_good = status_sync.output_good && !state_q.power_off;

  always_comb begin
    state_d                = state_q;
    state_d.card_good_prev = status_sync.card_good;
    state_d.deactivate     = 1'b0;

    if (conv_wr) begin
      // a rising power-off bit starts the deactivation sequence
      state_d.deactivate   = i_reg_req.wdata[`CSC_CONV_POWER_OFF]
                             && !state_q.power_off;
      state_d.power_off    = i_reg_req.wdata[`CSC_CONV_POWER_OFF];
      state_d.sens_adjust  = i_reg_req.wdata[`CSC_CONV_SENS_ADJUST];
      state_d.step_disable = i_reg_req.wdata[`CSC_CONV_STEP_DISABLE];
      // code changes alone leave cards powered
      state_d.code         = csc_pkg::csc_volt_t'(
                               i_reg_req.wdata[`CSC_CONV_CODE_MSB:`CSC_CONV_CODE_LSB]);
      // bit 4 is not stored and always reads zero
    end

    if (regu_wr) begin
      // low bits are held at one so a stray clear cannot reach the regulators
      state_d.boost = i_reg_req.wdata[`CSC_REG_BOOST_MSB:`CSC_REG_BOOST_LSB];
    end

    if (conv_rd) begin
      state_d.rdata = conv_read_value(state_q, output_good);
    end else if (regu_rd) begin
      state_d.rdata = reg_read_value(state_q);
    end

    // a new edge in the read cycle survives the read clear
    state_d.irq_flag = (state_q.irq_flag && !conv_rd) || card_good_rise;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q              <= '0;
      state_q.power_off    <= 1'b0;
      state_q.irq_flag     <= 1'b0;
      state_q.sens_adjust  <= 1'b0;
      state_q.step_disable <= 1'b0;
      state_q.code         <= csc_pkg::CSC_VOLT_0V0;
      state_q.boost        <= `CSC_BOOST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_reg_rdata                  = state_q.rdata;
  assign o_card_deactivate            = state_q.deactivate;
  assign o_conv_ctrl.enable           = !state_q.power_off;
  assign o_conv_ctrl.code             = state_q.code;
  assign o_conv_ctrl.sens_adjust      = state_q.sens_adjust;
  assign o_conv_ctrl.step_disable     = state_q.step_disable;
  assign o_regulator_current_boost    = state_q.boost;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  a_irq_flag_set: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    card_good_rise |=> state_q.irq_flag
  ) else $error("irq flag not set after card voltage good");

  a_irq_read_clear: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (conv_rd && !card_good_rise) |=> !state_q.irq_flag
  ) else $error("irq flag not cleared by read");

  a_irq_read_shows: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (conv_rd && state_q.irq_flag) |=> o_reg_rdata[`CSC_CONV_IRQ_FLAG]
  ) else $error("read lost the pending irq flag");

  a_output_good_bit: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    conv_rd |=> (o_reg_rdata[`CSC_CONV_OUTPUT_GOOD] ==
                 ($past(status_sync.output_good) && !$past(state_q.power_off)))
  ) else $error("output good bit wrong");

  a_zero_bit_four: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    conv_rd |=> !o_reg_rdata[`CSC_CONV_ZERO_BIT]
  ) else $error("bit 4 read back non-zero");

  a_power_off_deact: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (conv_wr && i_reg_req.wdata[`CSC_CONV_POWER_OFF] && o_conv_ctrl.enable)
      |=> (o_card_deactivate && !o_conv_ctrl.enable) ##1 !o_card_deactivate
  ) else $error("power off did not give one deactivation pulse");

  a_power_on_enable: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (conv_wr && !i_reg_req.wdata[`CSC_CONV_POWER_OFF]) |=> o_conv_ctrl.enable
  ) else $error("converter not re-enabled");

  a_code_no_deact: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (conv_wr && (i_reg_req.wdata[`CSC_CONV_POWER_OFF] == state_q.power_off))
      |=> !o_card_deactivate
  ) else $error("code change caused deactivation");

  a_code_output: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    conv_wr |=> (o_conv_ctrl.code ==
                 $past(i_reg_req.wdata[`CSC_CONV_CODE_MSB:`CSC_CONV_CODE_LSB]))
  ) else $error("voltage code not applied");

  a_sense_adjust: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    conv_wr |=> (o_conv_ctrl.sens_adjust == $past(i_reg_req.wdata[`CSC_CONV_SENS_ADJUST]))
  ) else $error("sensitivity bit not applied");

  a_boost_output: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    regu_wr |=> (o_regulator_current_boost ==
                 $past(i_reg_req.wdata[`CSC_REG_BOOST_MSB:`CSC_REG_BOOST_LSB]))
  ) else $error("boost bits not applied");

  a_reg_low_ones: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    regu_rd |=> (o_reg_rdata[`CSC_REG_FIXED_MSB:`CSC_REG_FIXED_LSB] == `CSC_REG_FIXED_VALUE)
  ) else $error("regulator low bits not ones");

  //////////////////////////////////////////////////////////////////////////////
  // reset, hold, read-back, deactivation pulse and irq flag checks

  // from the second reset edge on, as the first edge may still see power-up values
  a_reset_values: assert property (
    @(posedge i_clk_sys)
    (!i_rst_n ##1 !i_rst_n) |-> ((o_reg_rdata == `CSC_CONV_RESET) && o_conv_ctrl.enable &&
                                 (o_conv_ctrl.code == csc_pkg::CSC_VOLT_0V0) &&
                                 !o_conv_ctrl.sens_adjust && !o_conv_ctrl.step_disable &&
                                 !o_card_deactivate)
  ) else $error("converter register not at reset value");

  a_boost_reset: assert property (
    @(posedge i_clk_sys)
    (!i_rst_n ##1 !i_rst_n) |-> (o_regulator_current_boost == `CSC_BOOST_RESET)
  ) else $error("boost bits not at reset value");

  a_irq_reset: assert property (
    @(posedge i_clk_sys)
    (!i_rst_n ##1 !i_rst_n) |-> (!state_q.irq_flag && !state_q.power_off)
  ) else $error("flags not clear in reset");

  a_deact_one_cycle: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_card_deactivate |=> !o_card_deactivate
  ) else $error("deactivation pulse longer than one cycle");

  a_deact_stops_conv: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_card_deactivate |-> !o_conv_ctrl.enable
  ) else $error("deactivation while converter enabled");

  a_deact_only_off: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_card_deactivate |-> ($past(conv_wr) && $past(i_reg_req.wdata[`CSC_CONV_POWER_OFF]) &&
                           !$past(state_q.power_off))
  ) else $error("deactivation without a power-off write");

  a_irq_holds: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_q.irq_flag && !conv_rd) |=> state_q.irq_flag
  ) else $error("irq flag lost without a read");

  a_irq_no_cause: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (!state_q.irq_flag && !card_good_rise) |=> !state_q.irq_flag
  ) else $error("irq flag set without card voltage rise");

  a_irq_set_wins: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (conv_rd && card_good_rise) |=> state_q.irq_flag
  ) else $error("read clear beat a new irq event");

  a_good_forced_off: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (conv_rd && state_q.power_off) |=> !o_reg_rdata[`CSC_CONV_OUTPUT_GOOD]
  ) else $error("output good shown while converter off");

  a_read_power_off: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    conv_rd |=> (o_reg_rdata[`CSC_CONV_POWER_OFF] == $past(state_q.power_off))
  ) else $error("power-off bit read back wrong");

  a_read_code: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    conv_rd |=> (o_reg_rdata[`CSC_CONV_CODE_MSB:`CSC_CONV_CODE_LSB] == $past(state_q.code))
  ) else $error("voltage code read back wrong");

  a_read_sense: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    conv_rd |=> (o_reg_rdata[`CSC_CONV_SENS_ADJUST] == $past(state_q.sens_adjust))
  ) else $error("sensitivity bit read back wrong");

  a_read_boost: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    regu_rd |=> (o_reg_rdata[`CSC_REG_BOOST_MSB:`CSC_REG_BOOST_LSB] == $past(state_q.boost))
  ) else $error("boost bits read back wrong");

  a_rdata_holds: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !(conv_rd || regu_rd) |=> $stable(o_reg_rdata)
  ) else $error("read data changed without a read");

  a_code_holds: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !conv_wr |=> $stable(o_conv_ctrl.code)
  ) else $error("voltage code changed without a write");

  a_enable_holds: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !conv_wr |=> $stable(o_conv_ctrl.enable)
  ) else $error("converter enable changed without a write");

  a_boost_holds: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !regu_wr |=> $stable(o_regulator_current_boost)
  ) else $error("boost bits changed without a write");

endmodule : csc_config

// ==== rtl/csc_defines.svh ====
`ifndef CSC_DEFINES_SVH
`define CSC_DEFINES_SVH

// register indices on the host register port
`define CSC_IDX_CONVERTER      1'b0
`define CSC_IDX_REGULATOR      1'b1

// converter configuration register fields
`define CSC_CONV_POWER_OFF     7
`define CSC_CONV_IRQ_FLAG      6
`define CSC_CONV_OUTPUT_GOOD   5
`define CSC_CONV_ZERO_BIT      4
`define CSC_CONV_SENS_ADJUST   3
`define CSC_CONV_STEP_DISABLE  2
`define CSC_CONV_CODE_MSB      1
`define CSC_CONV_CODE_LSB      0

// regulator current boost register fields
`define CSC_REG_BOOST_MSB      7
`define CSC_REG_BOOST_LSB      4
`define CSC_REG_FIXED_MSB      3
`define CSC_REG_FIXED_LSB      0

// reset values
`define CSC_CONV_RESET         8'h00
`define CSC_REG_RESET          8'h0f
`define CSC_REG_FIXED_VALUE    4'hf
`define CSC_BOOST_RESET        4'h0
`define CSC_CODE_RESET         2'h0

// output voltage codes
`define CSC_CODE_0V0           2'h0
`define CSC_CODE_2V2           2'h1
`define CSC_CODE_3V2           2'h2
`define CSC_CODE_5V2           2'h3

`endif

// ==== rtl/csc_pkg.sv ====
package csc_pkg;

  typedef enum logic [1:0] {
    CSC_VOLT_0V0 = 2'b00,
    CSC_VOLT_2V2 = 2'b01,
    CSC_VOLT_3V2 = 2'b10,
    CSC_VOLT_5V2 = 2'b11
  } csc_volt_t;

  // one host register access, as delivered by the two-wire link decoder
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       sel;
    logic [7:0] wdata;
  } csc_reg_req_t;

  // controls toward the analog converter
  typedef struct packed {
    logic      enable;
    csc_volt_t code;
    logic      sens_adjust;
    logic      step_disable;
  } csc_conv_ctrl_t;

  // analog status inputs, also the synchroniser payload
  typedef struct packed {
    logic output_good;
    logic card_good;
  } csc_status_t;

  typedef struct packed {
    csc_status_t meta;
    csc_status_t stable;
  } csc_sync_t;

  typedef struct packed {
    logic        power_off;
    logic        irq_flag;
    logic        sens_adjust;
    logic        step_disable;
    csc_volt_t   code;
    logic [3:0]  boost;
    logic        card_good_prev;
    logic        deactivate;
    logic [7:0]  rdata;
  } csc_state_t;

endpackage : csc_pkg

// ==== rtl/csc_sync.sv ====
module csc_sync (
  input  wire logic                i_clk_sys,
  input  wire logic                i_rst_n,
  input  wire csc_pkg::csc_status_t i_async,
  output csc_pkg::csc_status_t     o_sync
);

  csc_pkg::csc_sync_t state_q;
  csc_pkg::csc_sync_t state_d;

  always_comb begin
    state_d        = state_q;
    state_d.meta   = i_async;
    state_d.stable = state_q.meta;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // only the second stage leaves this module
  assign o_sync = state_q.stable;

endmodule : csc_sync

// ==== testbench/test_csc_config.sv ====
module test_csc_config;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic       sel;
    logic [7:0] wdata;
    logic [7:0] exp_rd;
    logic [8:0] exp_ctl;
  } csc_tb_row_t;

  logic                     i_clk_sys = 1'b0;
  logic                     i_rst_n   = 1'b0;
  csc_pkg::csc_reg_req_t    req       = '0;
  csc_pkg::csc_status_t     status    = '0;
  logic [7:0]               o_reg_rdata;
  csc_pkg::csc_conv_ctrl_t  o_conv_ctrl;
  logic                     o_card_deactivate;
  logic [3:0]               o_regulator_current_boost;
  int                       miscompares = 0;
  int                       comparisons = 0;
  logic [8:0]               ctl;

  // ctl packs {enable, code, sens_adjust, step_disable, boost}
  csc_tb_row_t rows [10] = '{
    '{1'h0, 8'h01, 8'h01, 9'h140}, '{1'h0, 8'h02, 8'h02, 9'h180},
    '{1'h0, 8'h03, 8'h03, 9'h1c0}, '{1'h0, 8'h68, 8'h08, 9'h120},
    '{1'h0, 8'h04, 8'h04, 9'h110}, '{1'h0, 8'h00, 8'h00, 9'h100},
    '{1'h1, 8'h0f, 8'h0f, 9'h100}, '{1'h1, 8'hff, 8'hff, 9'h10f},
    '{1'h1, 8'haf, 8'haf, 9'h10a}, '{1'h1, 8'h5f, 8'h5f, 9'h105}
  };

  always #12.5 i_clk_sys = ~i_clk_sys;

  assign ctl = {o_conv_ctrl, o_regulator_current_boost};

  csc_config csc_config_i (
    .i_clk_sys                 (i_clk_sys),
    .i_rst_n                   (i_rst_n),
    .i_reg_req                 (req),
    .i_conv_status             (status),
    .o_reg_rdata               (o_reg_rdata),
    .o_conv_ctrl               (o_conv_ctrl),
    .o_card_deactivate         (o_card_deactivate),
    .o_regulator_current_boost (o_regulator_current_boost)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // outputs are sampled 1 ns after the edge that takes the access
  task automatic wr_reg(input logic sel, input logic [7:0] data);
    @(posedge i_clk_sys);
    req.wr    <= 1'b1;
    req.sel   <= sel;
    req.wdata <= data;
    @(posedge i_clk_sys);
    req.wr    <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic sel, input logic [7:0] exp);
    @(posedge i_clk_sys);
    req.rd  <= 1'b1;
    req.sel <= sel;
    @(posedge i_clk_sys);
    req.rd  <= 1'b0;
    #1;
    check(16'(o_reg_rdata), 16'(exp));
  endtask : rd_reg

  task automatic test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    #1;
    check(16'(ctl), 16'h0100);
    rd_reg(1'b0, 8'h00);
    rd_reg(1'b1, 8'h0f);
    foreach (rows[i]) begin
      wr_reg(rows[i].sel, rows[i].wdata);
      check(16'(o_card_deactivate), 16'h0000);
      check(16'(ctl), 16'(rows[i].exp_ctl));
      rd_reg(rows[i].sel, rows[i].exp_rd);
    end
    // flag set by card voltage rise, cleared by read
    @(posedge i_clk_sys);
    status <= 2'h3;
    repeat (4) @(posedge i_clk_sys);
    rd_reg(1'b0, 8'h60);
    rd_reg(1'b0, 8'h20);
    wr_reg(1'b0, 8'h83);
    check(16'(o_card_deactivate), 16'h0001);
    check(16'(ctl), 16'h00c5);
    @(posedge i_clk_sys);
    #1;
    check(16'(o_card_deactivate), 16'h0000);
    rd_reg(1'b0, 8'h83);
    wr_reg(1'b0, 8'h83);
    check(16'(o_card_deactivate), 16'h0000);
    wr_reg(1'b0, 8'h03);
    check(16'(o_card_deactivate), 16'h0000);
    check(16'(ctl), 16'h01c5);
    rd_reg(1'b0, 8'h23);
    // quiet status before the mid-run reset
    @(posedge i_clk_sys);
    status  <= 2'h0;
    repeat (3) @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    #1;
    check(16'(ctl), 16'h0100);
    check(16'(o_reg_rdata), 16'h0000);
    @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    rd_reg(1'b0, 8'h00);
    rd_reg(1'b1, 8'h0f);
    // rise lands in the read cycle: old flag read, new flag kept
    @(posedge i_clk_sys);
    status <= 2'h1;
    @(posedge i_clk_sys);
    rd_reg(1'b0, 8'h00);
    rd_reg(1'b0, 8'h40);
    test_done();
  end

  initial begin
    repeat (2000) @(posedge i_clk_sys);
    miscompares++;
    test_done();
  end
endmodule : test_csc_config
